// >>> src/analog_comparator_control_regs.vh
`ifndef ANALOG_COMPARATOR_CONTROL_REGS_VH
`define ANALOG_COMPARATOR_CONTROL_REGS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define CTRL_ZERO_FIRST_ADDR   8'h00
`define CTRL_ONE_FIRST_ADDR    8'h04
`define CTRL_ZERO_SECOND_ADDR  8'h08
`define CTRL_ONE_SECOND_ADDR   8'h0c
`define MIRROR_ADDR            8'h10
`define IRQ_CTRL_ADDR          8'h14

// ----------------------------------------------------------------------------
// First control register fields
// ----------------------------------------------------------------------------
`define ENABLE_BIT             7
`define RESULT_BIT             6
`define PIN_ENABLE_BIT         5
`define INVERT_BIT             4
`define SPEED_BIT              2
`define HYST_BIT               1
`define SYNC_BIT               0
`define CTRL_ZERO_WMASK        8'hb7
`define CTRL_ZERO_RESET        8'h04

// ----------------------------------------------------------------------------
// Second control register fields
// ----------------------------------------------------------------------------
`define RISE_EN_BIT            7
`define FALL_EN_BIT            6
`define POS_SEL_HI             5
`define POS_SEL_LO             4
`define NEG_SEL_HI             1
`define NEG_SEL_LO             0
`define CTRL_ONE_WMASK         8'hf3
`define CTRL_ONE_RESET         8'h00

// ----------------------------------------------------------------------------
// Interrupt control register fields
// ----------------------------------------------------------------------------
`define FLAG_FIRST_BIT         0
`define FLAG_SECOND_BIT        1
`define IRQ_EN_FIRST_BIT       2
`define IRQ_EN_SECOND_BIT      3
`define PERIPH_EN_BIT          4
`define GLOBAL_EN_BIT          5

// ----------------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------------
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2

`endif

// >>> src/comparator_sync_stage.v
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// Two-flop synchroniser for a bus of asynchronous levels.
// ----------------------------------------------------------------------------
module comparator_sync_stage #(
  parameter WIDTH = 2
) (
  input  wire             aclk,     // System clock.
  input  wire             aresetn,  // Synchronous reset, active low.
  input  wire [WIDTH-1:0] async_in, // Levels from outside the clock domain.
  output reg  [WIDTH-1:0] sync_out  // Synchronised levels.
);

  reg [WIDTH-1:0] meta_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // comparator_sync_stage

`default_nettype wire

// >>> src/comparator_channel.v
`timescale 1ns/100ps
`default_nettype none
`include "analog_comparator_control_regs.vh"

// ----------------------------------------------------------------------------
// One comparator: result latch, edge detectors, timer sync latch, routing.
// ----------------------------------------------------------------------------
module comparator_channel (
  input  wire       aclk,          // System clock.
  input  wire       aresetn,       // Synchronous reset, active low.
  input  wire [7:0] ctrl_zero,     // First control register.
  input  wire [7:0] ctrl_one,      // Second control register.
  input  wire       raw_sync,      // Synchronised analog comparison, 1 = pos > neg.
  input  wire       timer_fall,    // Falling edge of the timer one clock.
  output reg        result_reg,    // Latched polarity-corrected result.
  output reg        edge_hit,      // One-cycle pulse: enabled edge seen.
  output reg        pin_value_reg, // Result value towards pin and timer one.
  output reg  [1:0] pos_route_reg, // Positive input route.
  output reg  [1:0] neg_route_reg, // Negative input route.
  output reg        inputs_on_reg  // Inputs connected.
);

  wire enable  = ctrl_zero[`ENABLE_BIT];
  // A disabled comparator compares as zero, so on/off and polarity still move the result.
  wire res_now = (enable & raw_sync) ^ ctrl_zero[`INVERT_BIT];
  reg  started_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      result_reg    <= 1'b0;
      started_reg   <= 1'b0;
      edge_hit      <= 1'b0;
      pin_value_reg <= 1'b0;
      pos_route_reg <= 2'h0;
      neg_route_reg <= 2'h0;
      inputs_on_reg <= 1'b0;
    end else begin
      result_reg  <= res_now;
      started_reg <= 1'b1;
      edge_hit    <= started_reg &
                     ((ctrl_one[`RISE_EN_BIT] & res_now & ~result_reg) |
                      (ctrl_one[`FALL_EN_BIT] & ~res_now & result_reg));
      if (!ctrl_zero[`SYNC_BIT] || timer_fall) begin
        pin_value_reg <= res_now;
      end
      pos_route_reg <= ctrl_one[`POS_SEL_HI:`POS_SEL_LO];
      neg_route_reg <= ctrl_one[`NEG_SEL_HI:`NEG_SEL_LO];
      inputs_on_reg <= enable;
    end
  end

endmodule // comparator_channel

`default_nettype wire

// >>> src/analog_comparator_control.v
// Operation
// - Each comparator has rising and falling detectors; enabled firing sets its flag.
// - Rise enable bit 7 lets low-to-high result changes set the flag.
// - Fall enable bit 6 lets high-to-low result changes set the flag.
// - Software clears the flag; a same-cycle edge keeps it set.
// - Toggling invert or enable while disabled changes result and may flag.
// - Interrupt request needs flag, comparator, peripheral and global enables.
// - Positive select 00 pin, 01 DAC, 10 fixed reference, 11 ground.
// - Negative select picks one of four negative pins by value.
// - Comparator disabled disconnects all its inputs.
// - Result bit 6 reads comparison, inverted when invert bit set.
// - Pin enable drives result onto pin when direction bit clear.
// - Speed bit resets to one; one is fast, zero is low power.
// - Hysteresis bit one enables hysteresis; resets to zero.
// - Sync bit makes pin and timer result update on timer clock fall.
// - Mirror register bit 1 second result, bit 0 first result.
// - Enable bit 7 turns comparator on; resets to zero.
// - Unimplemented register bits read as zero.
// - Internal result latched every system cycle; pin unlatched unless synced.
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "analog_comparator_control_regs.vh"

module analog_comparator_control (
  input  wire        aclk,              // System clock, 25 MHz.
  input  wire        aresetn,           // Synchronous reset, active low.
  input  wire [7:0]  s_axi_awaddr,      // Write address.
  input  wire        s_axi_awvalid,     // Write address valid.
  output reg         s_axi_awready,     // Write address ready.
  input  wire [31:0] s_axi_wdata,       // Write data.
  input  wire [3:0]  s_axi_wstrb,       // Write byte strobes.
  input  wire        s_axi_wvalid,      // Write data valid.
  output reg         s_axi_wready,      // Write data ready.
  output reg  [1:0]  s_axi_bresp,       // Write response.
  output reg         s_axi_bvalid,      // Write response valid.
  input  wire        s_axi_bready,      // Write response ready.
  input  wire [7:0]  s_axi_araddr,      // Read address.
  input  wire        s_axi_arvalid,     // Read address valid.
  output reg         s_axi_arready,     // Read address ready.
  output reg  [31:0] s_axi_rdata,       // Read data.
  output reg  [1:0]  s_axi_rresp,       // Read response.
  output reg         s_axi_rvalid,      // Read data valid.
  input  wire        s_axi_rready,      // Read data ready.
  input  wire [1:0]  compare_in,        // Analog comparison results, bit n = comparator n.
  input  wire        timer_one_clock,   // Timer one source clock.
  input  wire [1:0]  pin_direction_bit, // Output pin direction bits, 1 = input.
  output reg  [1:0]  result_pin_out,    // Comparator output pin values.
  output reg  [1:0]  result_pin_oe_n,   // Pin output enables, low while driving.
  output reg  [1:0]  timer_gate_out,    // Results towards timer one.
  output reg  [3:0]  positive_route,    // Positive routes, [3:2] second, [1:0] first.
  output reg  [3:0]  negative_route,    // Negative routes, [3:2] second, [1:0] first.
  output reg  [1:0]  inputs_connected,  // Input switches closed per comparator.
  output reg  [1:0]  comparator_on,     // Analog enables.
  output reg  [1:0]  fast_mode,         // Speed selects.
  output reg  [1:0]  hysteresis_on,     // Hysteresis enables.
  output reg         irq_out            // Interrupt request to the processor.
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  // Both comparators keep private copies of their two control registers.
  // Index 0 is the first comparator and index 1 the second throughout.
  reg [7:0] ctrl_zero_reg [0:1];
  reg [7:0] ctrl_one_reg  [0:1];
  // Flags are set by hardware and cleared by software writing zero.
  reg [1:0] irq_flag_reg;
  reg [1:0] irq_en_reg;
  reg       periph_en_reg;
  reg       global_en_reg;
  reg       timer_prev_reg;

  // A write address or write data beat is parked here until its partner
  // arrives, so the two channels may be offered in either order.
  reg [7:0] awaddr_reg;
  reg       aw_held_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg       w_held_reg;

  // Outputs of the synchronisers and of the two channels.
  wire [2:0] sync_q;
  wire [1:0] result_q;
  wire [1:0] edge_q;
  wire [1:0] pin_q;
  wire [1:0] pos_q0;
  wire [1:0] pos_q1;
  wire [1:0] neg_q0;
  wire [1:0] neg_q1;
  wire [1:0] on_q;

  // Only writable bits move; a cleared low byte strobe leaves the byte alone.
  function [7:0] merge_byte;
    input [7:0] old_val;
    input [7:0] new_val;
    input [7:0] wmask;
    input       strobe;
    begin
      merge_byte = strobe ? ((old_val & ~wmask) | (new_val & wmask)) : old_val;
    end
  endfunction

  // The read view of the first control register inserts the live result bit
  // and forces the unimplemented bit to zero.
  function [7:0] zero_view;
    input [7:0] ctrl;
    input       res;
    begin
      zero_view = (ctrl & `CTRL_ZERO_WMASK) | ({7'h00, res} << `RESULT_BIT);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers and comparator channels
  // --------------------------------------------------------------------------
  // Comparison results and the timer clock come from outside the clock
  // domain and pass two flip-flops before any logic reads them.
  comparator_sync_stage #(
    .WIDTH(3)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({timer_one_clock, compare_in}),
    .sync_out (sync_q)
  );

  // The timer clock is sampled like a pin, so its low and high phases must
  // each last at least one system cycle for a fall to be seen.
  wire timer_fall = timer_prev_reg & ~sync_q[2];

  // Each channel latches its result every cycle and reports enabled edges.
  comparator_channel u_first (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .ctrl_zero     (ctrl_zero_reg[0]),
    .ctrl_one      (ctrl_one_reg[0]),
    .raw_sync      (sync_q[0]),
    .timer_fall    (timer_fall),
    .result_reg    (result_q[0]),
    .edge_hit      (edge_q[0]),
    .pin_value_reg (pin_q[0]),
    .pos_route_reg (pos_q0),
    .neg_route_reg (neg_q0),
    .inputs_on_reg (on_q[0])
  );

  comparator_channel u_second (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .ctrl_zero     (ctrl_zero_reg[1]),
    .ctrl_one      (ctrl_one_reg[1]),
    .raw_sync      (sync_q[1]),
    .timer_fall    (timer_fall),
    .result_reg    (result_q[1]),
    .edge_hit      (edge_q[1]),
    .pin_value_reg (pin_q[1]),
    .pos_route_reg (pos_q1),
    .neg_route_reg (neg_q1),
    .inputs_on_reg (on_q[1])
  );

  // --------------------------------------------------------------------------
  // Write channel
  // --------------------------------------------------------------------------
  // The register update happens in the cycle in which both halves are held
  // and no earlier response is still waiting to be taken.
  wire do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire wr_z0    = (awaddr_reg == `CTRL_ZERO_FIRST_ADDR);
  wire wr_o0    = (awaddr_reg == `CTRL_ONE_FIRST_ADDR);
  wire wr_z1    = (awaddr_reg == `CTRL_ZERO_SECOND_ADDR);
  wire wr_o1    = (awaddr_reg == `CTRL_ONE_SECOND_ADDR);
  wire wr_mir   = (awaddr_reg == `MIRROR_ADDR);
  wire wr_irq   = (awaddr_reg == `IRQ_CTRL_ADDR);
  wire wr_ok    = wr_z0 | wr_o0 | wr_z1 | wr_o1 | wr_mir | wr_irq;
  wire irq_wr   = do_write && wr_irq && wstrb_reg[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      ctrl_zero_reg[0] <= `CTRL_ZERO_RESET;
      ctrl_zero_reg[1] <= `CTRL_ZERO_RESET;
      ctrl_one_reg[0]  <= `CTRL_ONE_RESET;
      ctrl_one_reg[1]  <= `CTRL_ONE_RESET;
      irq_en_reg    <= 2'h0;
      periph_en_reg <= 1'b0;
      global_en_reg <= 1'b0;
    end else begin
      // Each ready pulses for one cycle and stays low while its beat is parked.
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_z0) begin
          ctrl_zero_reg[0] <= merge_byte(ctrl_zero_reg[0], wdata_reg[7:0],
                                         `CTRL_ZERO_WMASK, wstrb_reg[0]);
        end
        if (wr_o0) begin
          ctrl_one_reg[0] <= merge_byte(ctrl_one_reg[0], wdata_reg[7:0],
                                        `CTRL_ONE_WMASK, wstrb_reg[0]);
        end
        if (wr_z1) begin
          ctrl_zero_reg[1] <= merge_byte(ctrl_zero_reg[1], wdata_reg[7:0],
                                         `CTRL_ZERO_WMASK, wstrb_reg[0]);
        end
        if (wr_o1) begin
          ctrl_one_reg[1] <= merge_byte(ctrl_one_reg[1], wdata_reg[7:0],
                                        `CTRL_ONE_WMASK, wstrb_reg[0]);
        end
        // Enables are written here; the flags are handled in their own process.
        if (irq_wr) begin
          irq_en_reg    <= {wdata_reg[`IRQ_EN_SECOND_BIT], wdata_reg[`IRQ_EN_FIRST_BIT]};
          periph_en_reg <= wdata_reg[`PERIPH_EN_BIT];
          global_en_reg <= wdata_reg[`GLOBAL_EN_BIT];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt flags
  // --------------------------------------------------------------------------
  // A write of zero to a flag clears it, but an edge in the same cycle wins.
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_flag_reg <= 2'h0;
    end else if (irq_wr) begin
      irq_flag_reg <= ({wdata_reg[`FLAG_SECOND_BIT], wdata_reg[`FLAG_FIRST_BIT]} &
                       irq_flag_reg) | edge_q;
    end else begin
      irq_flag_reg <= irq_flag_reg | edge_q;
    end
  end

  // --------------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------------
  reg [7:0] rd_byte;
  reg       rd_ok;

  // The read byte is decoded from the address as it is offered; the slave
  // registers it at the edge that takes the address.
  always @* begin
    rd_byte = 8'h00;
    rd_ok   = 1'b1;
    if (s_axi_araddr == `CTRL_ZERO_FIRST_ADDR) begin
      rd_byte = zero_view(ctrl_zero_reg[0], result_q[0]);
    end else if (s_axi_araddr == `CTRL_ONE_FIRST_ADDR) begin
      rd_byte = ctrl_one_reg[0] & `CTRL_ONE_WMASK;
    end else if (s_axi_araddr == `CTRL_ZERO_SECOND_ADDR) begin
      rd_byte = zero_view(ctrl_zero_reg[1], result_q[1]);
    end else if (s_axi_araddr == `CTRL_ONE_SECOND_ADDR) begin
      rd_byte = ctrl_one_reg[1] & `CTRL_ONE_WMASK;
    end else if (s_axi_araddr == `MIRROR_ADDR) begin
      rd_byte = {6'h00, result_q[1], result_q[0]};
    end else if (s_axi_araddr == `IRQ_CTRL_ADDR) begin
      rd_byte = {2'h0, global_en_reg, periph_en_reg, irq_en_reg, irq_flag_reg};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      // A new read is taken only once the previous data has been accepted.
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs towards pins, analog and processor
  // --------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      timer_prev_reg   <= 1'b0;
      result_pin_out   <= 2'h0;
      result_pin_oe_n  <= 2'h3;
      timer_gate_out   <= 2'h0;
      positive_route   <= 4'h0;
      negative_route   <= 4'h0;
      inputs_connected <= 2'h0;
      comparator_on    <= 2'h0;
      fast_mode        <= 2'h3;
      hysteresis_on    <= 2'h0;
      irq_out          <= 1'b0;
    end else begin
      timer_prev_reg   <= sync_q[2];
      result_pin_out   <= pin_q;
      timer_gate_out   <= pin_q;
      // The pin is driven only while its enable is set and its direction is output.
      result_pin_oe_n  <= ~({ctrl_zero_reg[1][`PIN_ENABLE_BIT],
                             ctrl_zero_reg[0][`PIN_ENABLE_BIT]} & ~pin_direction_bit);
      positive_route   <= {pos_q1, pos_q0};
      negative_route   <= {neg_q1, neg_q0};
      inputs_connected <= on_q;
      // Enable copies come from the same stage as the input switches, so both agree.
      comparator_on    <= on_q;
      fast_mode        <= {ctrl_zero_reg[1][`SPEED_BIT], ctrl_zero_reg[0][`SPEED_BIT]};
      hysteresis_on    <= {ctrl_zero_reg[1][`HYST_BIT], ctrl_zero_reg[0][`HYST_BIT]};
      // The request follows the flag and all three enables one cycle later.
      irq_out          <= |(irq_flag_reg & irq_en_reg) & periph_en_reg & global_en_reg;
    end
  end

endmodule // analog_comparator_control

`default_nettype wire

// >>> tb/analog_comparator_control_props.sv
`timescale 1ns/100ps
`default_nettype none
module analog_comparator_control_checker (
  input wire logic       aclk,              // Clock.
  input wire logic       aresetn,           // Reset.
  input wire logic       s_axi_bvalid,      // Write response.
  input wire logic       s_axi_bready,      // Response taken.
  input wire logic       s_axi_rvalid,      // Read data.
  input wire logic       s_axi_rready,      // Data taken.
  input wire logic [1:0] pin_direction_bit, // Pin directions.
  input wire logic [1:0] result_pin_out,    // Pin values.
  input wire logic [1:0] result_pin_oe_n,   // Pin enables.
  input wire logic [1:0] timer_gate_out,    // Timer results.
  input wire logic [1:0] inputs_connected,  // Input switches.
  input wire logic [1:0] comparator_on,     // Enables.
  input wire logic [1:0] fast_mode,         // Speed.
  input wire logic [1:0] hysteresis_on      // Hysteresis.
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_inputs_gate;
    inputs_connected == comparator_on;
  endproperty
  a_inputs_gate: assert property (p_inputs_gate)
    else $error("input switches differ from enable");
  property p_oe_dir0;
    !result_pin_oe_n[0] |-> !$past(pin_direction_bit[0]);
  endproperty
  a_oe_dir0: assert property (p_oe_dir0)
    else $error("pin 0 driven while direction is input");
  property p_oe_dir1;
    $past(pin_direction_bit[1]) |-> result_pin_oe_n[1];
  endproperty
  a_oe_dir1: assert property (p_oe_dir1)
    else $error("pin 1 driven while direction is input");
  property p_gate_pin;
    timer_gate_out == result_pin_out;
  endproperty
  a_gate_pin: assert property (p_gate_pin)
    else $error("timer result differs from pin result");
  property p_reset_fast;
    $rose(aresetn) |-> fast_mode == 2'h3;
  endproperty
  a_reset_fast: assert property (p_reset_fast)
    else $error("speed select not one after reset");
  property p_reset_off;
    $rose(aresetn) |-> comparator_on == 2'h0 && hysteresis_on == 2'h0 && result_pin_oe_n == 2'h3;
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("enables not clear after reset");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_done: assert property (p_b_done)
    else $error("write response not released");
  property p_r_done;
    $fell(s_axi_rvalid) |-> $past(s_axi_rready);
  endproperty
  a_r_done: assert property (p_r_done)
    else $error("read data dropped before taken");
endmodule // analog_comparator_control_checker

bind analog_comparator_control analog_comparator_control_checker i_checker (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready,
  .pin_direction_bit, .result_pin_out, .result_pin_oe_n, .timer_gate_out,
  .inputs_connected, .comparator_on, .fast_mode, .hysteresis_on);
`default_nettype wire

// >>> tb/test_analog_comparator_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_analog_comparator_control;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, timer_one_clock;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  compare_in, pin_direction_bit;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_out;
  wire [1:0]   s_axi_bresp, s_axi_rresp, result_pin_out, result_pin_oe_n, timer_gate_out;
  wire [1:0]   inputs_connected, comparator_on, fast_mode, hysteresis_on;
  wire [3:0]   positive_route, negative_route;
  wire [31:0]  s_axi_rdata;
  int          n_errors, compares, cycles;

  analog_comparator_control i_analog_comparator_control (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .compare_in, .timer_one_clock, .pin_direction_bit, .result_pin_out,
    .result_pin_oe_n, .timer_gate_out, .positive_route, .negative_route, .inputs_connected,
    .comparator_on, .fast_mode, .hysteresis_on, .irq_out);

  always #20 aclk = ~aclk;

  // ----
  // Bus tasks and checks
  // ----
  task automatic give_verdict;
    $display("counts: %0d compares, %0d errors", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er, "bresp");
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h0, e}, "rdata");
    chk(s_axi_rresp, er, "rresp");
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      give_verdict();
    end
  end

  // ----
  // Test sequence
  // ----
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h0;
    {s_axi_rready, timer_one_clock, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 50'h0;
    s_axi_wstrb = 4'hf;
    compare_in = 2'h0;
    pin_direction_bit = 2'h3;
    tick(2);
    aresetn <= 1'b1;
    chk(fast_mode, 2'h3, "fast");
    rd(8'h00, 8'h04);
    rd(8'h04, 8'h00);
    rd(8'h08, 8'h04);
    rd(8'h0c, 8'h00);
    rd(8'h10, 8'h00);
    $display("test reset done");
    wr(8'h00, 8'hff);
    tick(8);
    rd(8'h00, 8'hf7);
    chk({comparator_on[0], hysteresis_on[0], inputs_connected}, 4'hd, "copies");
    wr(8'h04, 8'hff);
    rd(8'h04, 8'hf3);
    rd(8'h10, 8'h01);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h01);
    wr(8'h18, 8'h55, 2'h2);
    rd(8'h18, 8'h00, 2'h2);
    $display("test bits done");
    for (int v = 0; v < 4; v++) begin
      wr(8'h04, 8'(v * 17));
      wr(8'h0c, 8'((3 - v) * 17));
      tick(2);
      chk(positive_route, (3 - v) * 4 + v, "pos route");
      chk(negative_route, (3 - v) * 4 + v, "neg route");
    end
    $display("test routes done");
    wr(8'h00, 8'h80);
    tick(8);
    chk(fast_mode, 2'h2, "low power");
    wr(8'h14, 8'h00);
    wr(8'h04, 8'h80);
    compare_in <= 2'h1;
    tick(8);
    rd(8'h14, 8'h01);
    chk(irq_out, 1'b0, "irq masked");
    wr(8'h14, 8'h35);
    tick(2);
    chk(irq_out, 1'b1, "irq on");
    wr(8'h14, 8'h15);
    tick(2);
    chk(irq_out, 1'b0, "irq global off");
    wr(8'h14, 8'h34);
    rd(8'h14, 8'h34);
    compare_in <= 2'h0;
    tick(8);
    rd(8'h14, 8'h34);
    wr(8'h04, 8'h40);
    compare_in <= 2'h1;
    tick(8);
    rd(8'h14, 8'h34);
    compare_in <= 2'h0;
    tick(8);
    rd(8'h14, 8'h35);
    chk(irq_out, 1'b1, "irq fall");
    wr(8'h14, 8'h00);
    wr(8'h0c, 8'h80);
    wr(8'h08, 8'h14);
    tick(8);
    rd(8'h14, 8'h02);
    rd(8'h10, 8'h02);
    rd(8'h08, 8'h54);
    $display("test interrupt done");
    wr(8'h00, 8'ha1);
    pin_direction_bit <= 2'h2;
    compare_in <= 2'h1;
    tick(8);
    chk(result_pin_out[0], 1'b0, "sync hold");
    chk(result_pin_oe_n, 2'h2, "pin drive");
    timer_one_clock <= 1'b1;
    tick(4);
    timer_one_clock <= 1'b0;
    tick(8);
    chk(result_pin_out[0], 1'b1, "sync update");
    chk(timer_gate_out[0], 1'b1, "timer sync");
    wr(8'h00, 8'ha0);
    compare_in <= 2'h0;
    tick(8);
    chk(result_pin_out[0], 1'b0, "async pin");
    pin_direction_bit <= 2'h3;
    tick(2);
    chk(result_pin_oe_n, 2'h3, "pin released");
    $display("test pin done");
    give_verdict();
  end
endmodule // test_analog_comparator_control
`default_nettype wire
